// file: design/hses_pkg.sv
// Package for the hot swap extra status register block
package hses_pkg;
  // Command code of the extra status register
  localparam logic [7:0] HSES_CMD_EXTRA_STATUS = 8'h80;
  // Reset value of the register
  localparam logic [7:0] HSES_RESET_VALUE = 8'h00;
  // Bit positions
  localparam int HSES_BIT_SHORT = 7;
  localparam int HSES_BIT_UV = 6;
  localparam int HSES_BIT_OV = 5;
  localparam int HSES_BIT_AUX = 4;
  localparam int HSES_BIT_LIMIT = 3;
  localparam int HSES_BIT_WARN2 = 0;
  // Status word bit carrying the summary
  localparam int HSES_SUMMARY_BIT = 12;
  // Shutdown reason codes
  typedef enum logic [1:0] {
    HSES_CAUSE_NONE = 2'h0,
    HSES_CAUSE_OC = 2'h1,
    HSES_CAUSE_UV = 2'h2,
    HSES_CAUSE_OV = 2'h3
  } hses_cause_t;
  // Raw events and live levels from the surrounding device
  typedef struct packed {
    logic short_seen;
    logic uv_live;
    logic ov_live;
    logic aux_any;
    logic limiting;
    logic oc_timed;
    logic uv_fault;
    logic ov_fault;
  } hses_evt_t;
  // Register byte layout
  typedef struct packed {
    logic pass_switch_suspect_short;
    logic undervolt_compare_live;
    logic overvolt_compare_live;
    logic aux_voltage_summary;
    logic current_limit_active_flag;
    hses_cause_t shutdown_reason;
    logic second_current_warning;
  } hses_reg_t;
endpackage : hses_pkg

// file: design/hses_sticky.sv
// Sticky flag with set winning over clear
`timescale 1ns/10ps
module hses_sticky (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);
  // Flag register, set has priority over clear
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_flag <= 1'h0;
    end else if (i_set) begin
      o_flag <= 1'h1;
    end else if (i_clear) begin
      o_flag <= 1'h0;
    end
  end
endmodule : hses_sticky

// file: design/hses_extra_status.sv
// Hot swap extra status register with summary and read port
//
// Contract
// - bit 7 latches suspected shorted pass switch
// - bit 6 live undervoltage comparator level
// - bit 5 live overvoltage comparator level
// - bit 4 latches any aux status active
// - bit 3 latches immediately on current limiting
// - timed overcurrent only after full timer
// - bits 2:1 hold latched shutdown cause
// - bit 0 latches second current warning crossing
// - read-only at 0x80, resets to 0x00
// - status word bit 12 summarises register
`timescale 1ns/10ps
module hses_extra_status (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire hses_pkg::hses_evt_t i_evt,
  input wire logic [11:0] i_current_code,
  input wire logic [11:0] i_second_current_threshold,
  input wire logic i_second_warn_polarity_select,
  input wire logic i_clear_faults,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_read_req,
  output logic [7:0] o_read_data,
  output logic o_read_hit,
  output logic o_vendor_status_summary
);
  import hses_pkg::*;

  // Latched flags, one per sticky bit, and the live second warning compare
  logic short_flag; // Suspected shorted pass switch seen
  logic aux_flag; // Some aux voltage status was active
  logic limit_flag; // Current limiting was seen
  logic warn2_flag; // Second current warning was seen
  logic warn2_cross; // Live second warning compare result
  // Shutdown reason state and its next value
  hses_cause_t cause_reg; // Latched shutdown reason
  hses_cause_t cause_next; // Next shutdown reason
  // Register byte as a host would read it now
  hses_reg_t view; // Assembled register byte

  // Second warning compare, polarity picks over or under
  always_comb begin
    if (i_second_warn_polarity_select) begin
      warn2_cross = i_current_code > i_second_current_threshold;
    end else begin
      warn2_cross = i_current_code < i_second_current_threshold;
    end
  end

  // Sticky flags, one instance per latched bit
  // Bit 7, suspected short of the pass switch
  hses_sticky u_short (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_set(i_evt.short_seen), .i_clear(i_clear_faults),
    .o_flag(short_flag));
  // Bit 4, summary of the aux voltage status
  hses_sticky u_aux (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_set(i_evt.aux_any), .i_clear(i_clear_faults),
    .o_flag(aux_flag));
  // Bit 3, untimed current limiting
  hses_sticky u_limit (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_set(i_evt.limiting), .i_clear(i_clear_faults),
    .o_flag(limit_flag));
  // Bit 0, second current warning; set again while still crossing
  hses_sticky u_warn2 (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_set(warn2_cross), .i_clear(i_clear_faults),
    .o_flag(warn2_flag));

  // Shutdown reason next value; a new cause overwrites, OV first
  always_comb begin
    if (i_evt.ov_fault) begin
      cause_next = HSES_CAUSE_OV;
    end else if (i_evt.uv_fault) begin
      cause_next = HSES_CAUSE_UV;
    end else if (i_evt.oc_timed) begin
      cause_next = HSES_CAUSE_OC;
    end else if (i_clear_faults) begin
      cause_next = HSES_CAUSE_NONE;
    end else begin
      cause_next = cause_reg;
    end
  end

  // Shutdown reason register
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      cause_reg <= HSES_CAUSE_NONE;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // Assemble register view; comparator bits are live
  always_comb begin
    view.pass_switch_suspect_short = short_flag;
    view.undervolt_compare_live = i_evt.uv_live;
    view.overvolt_compare_live = i_evt.ov_live;
    view.aux_voltage_summary = aux_flag;
    view.current_limit_active_flag = limit_flag;
    view.shutdown_reason = cause_reg;
    view.second_current_warning = warn2_flag;
  end

  // Read decode; combinational hit flag
  assign o_read_hit = i_read_req && (i_cmd_code == HSES_CMD_EXTRA_STATUS);

  // Read data and summary come from flip-flops
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      // Both outputs return to zero while reset is held
      o_read_data <= HSES_RESET_VALUE;
      o_vendor_status_summary <= 1'h0;
    end else begin
      // Summary follows the whole byte with one cycle of lag
      o_vendor_status_summary <= |view;
      if (o_read_hit) begin
        // Only a hit refreshes the data; other codes leave it alone
        o_read_data <= view;
      end
    end
  end

  // Checks
  // All checks share the system clock and rest while reset is held
  default clocking hses_cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  // Current limiting latches bit 3 on the very next edge
  chk_limit_sets: assert property (
    i_evt.limiting |=> limit_flag)
    else $error("limit flag not set");

  // A suspected short shows in bit 7 one edge later
  chk_short_sets: assert property (
    i_evt.short_seen |=> view.pass_switch_suspect_short)
    else $error("short flag not set");

  // A read returns the undervoltage level seen at the taken edge
  chk_uv_live: assert property (
    o_read_hit |=> o_read_data[HSES_BIT_UV] == $past(i_evt.uv_live))
    else $error("uv bit not live");

  // A read returns the overvoltage level seen at the taken edge
  chk_ov_live: assert property (
    o_read_hit |=> o_read_data[HSES_BIT_OV] == $past(i_evt.ov_live))
    else $error("ov bit not live");

  // Any aux voltage status latches bit 4
  chk_aux_sets: assert property (
    i_evt.aux_any |=> aux_flag)
    else $error("aux flag not set");

  // Timed overcurrent alone records its own cause
  chk_oc_cause: assert property (
    i_evt.oc_timed && !i_evt.uv_fault && !i_evt.ov_fault
    |=> cause_reg == HSES_CAUSE_OC)
    else $error("oc cause wrong");

  // Undervoltage wins over overcurrent but not over overvoltage
  chk_uv_cause: assert property (
    i_evt.uv_fault && !i_evt.ov_fault |=> cause_reg == HSES_CAUSE_UV)
    else $error("uv cause wrong");

  // Overvoltage always wins the cause field
  chk_ov_cause: assert property (
    i_evt.ov_fault |=> cause_reg == HSES_CAUSE_OV)
    else $error("ov cause wrong");

  // A clear with no new cause empties the cause field
  chk_cause_clear: assert property (
    i_clear_faults && !i_evt.oc_timed && !i_evt.uv_fault && !i_evt.ov_fault
    |=> cause_reg == HSES_CAUSE_NONE)
    else $error("cause not cleared");

  // A recorded cause stays put until cleared or replaced
  chk_cause_hold: assert property (
    cause_reg != HSES_CAUSE_NONE && !i_clear_faults
    && !i_evt.oc_timed && !i_evt.uv_fault && !i_evt.ov_fault
    |=> $stable(cause_reg))
    else $error("cause lost");

  // Over mode: current above the limit latches bit 0
  chk_warn2_sets: assert property (
    i_second_warn_polarity_select
    && (i_current_code > i_second_current_threshold) |=> warn2_flag)
    else $error("warn2 not set");

  // Under mode: current below the limit latches bit 0
  chk_warn2_under: assert property (
    !i_second_warn_polarity_select
    && (i_current_code < i_second_current_threshold) |=> warn2_flag)
    else $error("warn2 under not set");

  // A hit returns the byte as it stood at the taken edge
  chk_read_value: assert property (
    o_read_hit |=> o_read_data == $past(view))
    else $error("read data wrong");

  // Without a hit the read data must not move
  chk_read_refused: assert property (
    !o_read_hit |=> $stable(o_read_data))
    else $error("read data moved");

  // Summary is the OR of the byte one cycle earlier
  chk_summary_bit: assert property (
    ##1 o_vendor_status_summary == |$past(view))
    else $error("summary wrong");

  // The current limit flag survives until a clear arrives
  chk_flags_hold: assert property (
    limit_flag && !i_clear_faults |=> limit_flag)
    else $error("flag lost");

  // Scenario covers
  cov_limit: cover property (
    i_evt.limiting ##1 limit_flag);
  cov_clear: cover property (
    limit_flag ##1 i_clear_faults ##1 !limit_flag);
  cov_read: cover property (
    o_read_hit ##1 o_read_data != HSES_RESET_VALUE);
  cov_warn2_under: cover property (
    !i_second_warn_polarity_select && warn2_cross ##1 warn2_flag);
endmodule : hses_extra_status

// file: bench/hses_host.sv
// Host model that issues one-byte status reads
`timescale 1ns/10ps
module hses_host (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_go,
  input wire logic [7:0] i_code,
  output logic [7:0] o_cmd_code,
  output logic o_read_req
);
  // One-edge request; the idle code shifts left, taking in its inverted top bit, so nothing stale looks valid
  always_ff @(posedge i_sys_clk) begin
    o_read_req <= i_resetn & i_go;
    o_cmd_code <= i_go ? i_code : {o_cmd_code[6:0], ~o_cmd_code[7]};
  end
endmodule : hses_host

// file: bench/hot_swap_extra_status_register_test.sv
// Self-checking bench for the extra status register
`timescale 1ns/10ps
module hot_swap_extra_status_register_test;
  import hses_pkg::*;
  logic clk = 1'b0, resetn, go, clr, pol, hit, summ, req;
  logic [7:0] rcode, cmd, rdata, e, x;
  logic [11:0] cur, thr;
  logic [15:0] lfsr_q = 16'h1000;
  hses_evt_t evt;
  int num_errors = 0, cmp_count = 0;
  // 100 ns clock
  always #50 clk = ~clk;
  hses_host host (.i_sys_clk(clk), .i_resetn(resetn), .i_go(go),
    .i_code(rcode), .o_cmd_code(cmd), .o_read_req(req));
  hses_extra_status DUT (.i_sys_clk(clk), .i_resetn(resetn), .i_evt(evt),
    .i_current_code(cur), .i_second_current_threshold(thr),
    .i_second_warn_polarity_select(pol), .i_clear_faults(clr),
    .i_cmd_code(cmd), .i_read_req(req), .o_read_data(rdata),
    .o_read_hit(hit), .o_vendor_status_summary(summ));
  // Pseudo-random source
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // Expected byte: latched event bits, cause by priority, strict compare
  function automatic logic [7:0] expect_reg(input logic [7:0] v,
    input logic [11:0] c, input logic [11:0] t, input logic p);
    logic [1:0] cause;
    cause = v[0] ? 2'b11 : v[1] ? 2'b10 : v[2] ? 2'b01 : 2'b00;
    return {v[7:3], cause, p ? c > t : c < t};
  endfunction : expect_reg
  // Compare and count
  task automatic check(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Read through the host; data lands one edge after the taken edge
  task automatic do_read(input logic [7:0] code, input logic [7:0] exp);
    go = 1'b1;
    rcode = code;
    @(posedge clk);
    #5 go = 1'b0;
    check("read_hit", {7'h00, hit}, {7'h00, code == 8'h80});
    @(posedge clk);
    #5 check("read_data", rdata, exp);
  endtask : do_read
  // Verdict
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    resetn = 1'b0;
    {go, clr, pol, rcode, cur, thr} = '0;
    evt = '0;
    repeat (4) @(posedge clk);
    #5 resetn = 1'b1;
    do_read(8'h80, 8'h00);
    check("summary", {7'h00, summ}, 8'h00);
    $display("test reset done");
    for (int n = 0; n < 40; n++) begin
      // New compare inputs go in before the clear, so an old crossing
      // cannot survive the clear through set-over-clear priority
      lfsr_q = lfsr_next(lfsr_q);
      {pol, e} = lfsr_q[8:0];
      lfsr_q = lfsr_next(lfsr_q);
      cur = lfsr_q[11:0];
      lfsr_q = lfsr_next(lfsr_q);
      thr = lfsr_q[11:0];
      // Corners: all causes at once, then an equal compare
      if (n == 0) {e, cur, thr, pol} = {8'h07, 12'hFFF, 12'hFFE, 1'h1};
      if (n == 1) {e, cur, thr, pol} = {8'h02, 12'h123, 12'h123, 1'h0};
      clr = 1'h1;
      @(posedge clk);
      #5 clr = 1'h0;
      evt = hses_evt_t'(e);
      @(posedge clk);
      #5 evt = hses_evt_t'(e & 8'h60);
      x = expect_reg(e, cur, thr, pol);
      @(posedge clk);
      #5 do_read(8'h80, x);
      check("summary", {7'h00, summ}, {7'h00, |x});
      do_read({1'b0, e[6:0]}, x);
      clr = 1'b1;
      @(posedge clk);
      #5 clr = 1'b0;
      do_read(8'h80, expect_reg(e & 8'h60, cur, thr, pol));
      $display("test %0d done", n);
    end
    // Events together with a clear: set wins, then a mid-run reset
    cur = thr;
    clr = 1'h1;
    evt = hses_evt_t'(8'h9F);
    @(posedge clk);
    #5 evt = '0;
    clr = 1'h0;
    x = expect_reg(8'h9F, cur, thr, pol);
    do_read(HSES_CMD_EXTRA_STATUS, x);
    resetn = 1'h0;
    repeat (4) @(posedge clk);
    #5 resetn = 1'h1;
    check("reset_data", rdata, HSES_RESET_VALUE);
    check("reset_summary", {7'h00, summ}, 8'h00);
    do_read(HSES_CMD_EXTRA_STATUS, HSES_RESET_VALUE);
    $display("test mid reset done");
    complete_run();
  end
endmodule : hot_swap_extra_status_register_test
